// >>> sirq_pkg.sv
package sirq_pkg;
  // =====================================================
  // Frame layout
  localparam int unsigned SIRQ_FRAMES = 32;
  localparam int unsigned SIRQ_SOURCES = 21;
  localparam logic [1:0] SIRQ_PH_SAMPLE = 2'h2;
  localparam logic [1:0] SIRQ_PH_RECOVER = 2'h0;
  localparam logic [1:0] SIRQ_PH_TURN = 2'h1;
  localparam logic [4:0] SIRQ_LAST_FRAME = 5'h1F;
  // =====================================================
  // Link timing in link clocks
  localparam logic [3:0] SIRQ_START_LOW = 4'h4;
  localparam logic [3:0] SIRQ_START_LOW_MIN = 4'h4;
  localparam logic [3:0] SIRQ_START_LOW_MAX = 4'h8;
  localparam logic [1:0] SIRQ_STOP_QUIET = 2'h2;
  localparam logic [1:0] SIRQ_STOP_CONT = 2'h3;
  localparam logic [3:0] SIRQ_IDLE_GAP = 4'h8;
  // =====================================================
  // Reset values
  localparam logic SIRQ_QUIET_RST = 1'b0;
  localparam logic [SIRQ_SOURCES-1:0] SIRQ_DEFAULT_STATES = 21'h000000;

  typedef enum logic [1:0] {
    SIRQ_D_IDLE = 2'b00,
    SIRQ_D_START = 2'b01,
    SIRQ_D_FRAMES = 2'b10,
    SIRQ_D_STOP = 2'b11
  } sirq_dev_state_t;

  typedef enum logic [2:0] {
    SIRQ_H_IDLE = 3'b000,
    SIRQ_H_START = 3'b001,
    SIRQ_H_START_HI = 3'b010,
    SIRQ_H_FRAMES = 3'b011,
    SIRQ_H_STOP = 3'b100
  } sirq_host_state_t;
endpackage

// >>> sirq_if.sv
interface sirq_if (
  input wire logic link_clk
);
  logic dev_out;
  logic dev_oe;
  logic host_out;
  logic host_oe;
  logic serial_irq_line;

  // =====================================================
  // Wired line with pull-up: any low driver wins
  assign serial_irq_line = ~((dev_oe & ~dev_out) | (host_oe & ~host_out)); // R1

  modport device (
    input link_clk,
    input serial_irq_line,
    output dev_out,
    output dev_oe
  );

  modport host (
    input link_clk,
    input serial_irq_line,
    output host_out,
    output host_oe
  );
endinterface

// >>> sirq_host.sv
module sirq_host (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic quiet_req_in,
  output logic [sirq_pkg::SIRQ_SOURCES-1:0] irq_state_out,
  output logic irq_valid_out,
  output logic irq_update_out,
  sirq_if.host link
);
  import sirq_pkg::*;

  // =====================================================
  // Mode request into link domain
  logic [2:0] quiet_sync_reg;
  logic quiet_req_reg;
  always_ff @(posedge link.link_clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quiet_sync_reg <= 3'h0;
      quiet_req_reg <= 1'b0;
    end else begin
      quiet_sync_reg <= {quiet_sync_reg[1:0], quiet_req_in};
      if (quiet_sync_reg[1] == quiet_sync_reg[2]) begin
        quiet_req_reg <= quiet_sync_reg[2];
      end
    end
  end

  // =====================================================
  // Cycle sequencer on the link clock
  sirq_host_state_t st_reg;
  logic [3:0] cnt_reg;
  logic [1:0] phase_reg;
  logic [4:0] frame_reg;
  logic quiet_mode_reg;
  logic stop_quiet_reg;
  logic [SIRQ_SOURCES-1:0] shift_reg;
  logic [SIRQ_SOURCES-1:0] word_reg;
  logic word_tgl_reg;

  always_ff @(posedge link.link_clk or negedge rst_n_in) begin // R2
    if (!rst_n_in) begin
      st_reg <= SIRQ_H_START; // R7 R18
      cnt_reg <= 4'h0;
      phase_reg <= SIRQ_PH_TURN;
      frame_reg <= 5'h0;
      quiet_mode_reg <= SIRQ_QUIET_RST;
      stop_quiet_reg <= 1'b0;
    end else begin
      unique case (st_reg)
        SIRQ_H_IDLE: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (!link.serial_irq_line) begin
            // Peripheral pulse already counts as first low clock
            st_reg <= SIRQ_H_START; // R5
            cnt_reg <= 4'h1;
          end else if (!quiet_mode_reg && cnt_reg >= SIRQ_IDLE_GAP) begin
            st_reg <= SIRQ_H_START; // R6
            cnt_reg <= 4'h0;
          end
        end
        SIRQ_H_START: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == SIRQ_START_LOW - 4'h1) begin
            st_reg <= SIRQ_H_START_HI; // R5 R6
          end
        end
        SIRQ_H_START_HI: begin
          st_reg <= SIRQ_H_FRAMES; // R3
          phase_reg <= SIRQ_PH_TURN;
          frame_reg <= 5'h0;
        end
        SIRQ_H_FRAMES: begin
          unique case (phase_reg)
            SIRQ_PH_SAMPLE: phase_reg <= SIRQ_PH_RECOVER;
            SIRQ_PH_RECOVER: phase_reg <= SIRQ_PH_TURN;
            default: phase_reg <= SIRQ_PH_SAMPLE;
          endcase
          if (phase_reg == SIRQ_PH_SAMPLE) begin
            if (frame_reg == SIRQ_LAST_FRAME) begin
              st_reg <= SIRQ_H_STOP; // R16
              cnt_reg <= 4'h0;
              stop_quiet_reg <= quiet_req_reg;
            end
            frame_reg <= frame_reg + 5'h1;
          end
        end
        SIRQ_H_STOP: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == {2'h0, (stop_quiet_reg ? SIRQ_STOP_QUIET : SIRQ_STOP_CONT)} - 4'h1) begin
            st_reg <= SIRQ_H_IDLE; // R15 R17
            quiet_mode_reg <= stop_quiet_reg;
            cnt_reg <= 4'h0;
          end
        end
        default: st_reg <= SIRQ_H_IDLE;
      endcase
    end
  end

  // Sample each assigned frame; a low line means active
  always_ff @(posedge link.link_clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_reg <= SIRQ_DEFAULT_STATES;
      word_reg <= SIRQ_DEFAULT_STATES;
      word_tgl_reg <= 1'b0;
    end else if (st_reg == SIRQ_H_FRAMES && phase_reg == SIRQ_PH_SAMPLE) begin
      if (frame_reg < 5'(SIRQ_SOURCES)) begin
        shift_reg[frame_reg] <= ~link.serial_irq_line; // R13 R14
      end
      if (frame_reg == SIRQ_LAST_FRAME) begin
        word_reg <= shift_reg;
        word_tgl_reg <= ~word_tgl_reg;
      end
    end
  end

  // Low-driving start and stop, one high clock ending start
  assign link.host_oe = (st_reg == SIRQ_H_START) || (st_reg == SIRQ_H_START_HI) ||
                        (st_reg == SIRQ_H_STOP); // R1
  assign link.host_out = (st_reg == SIRQ_H_START_HI);

  // =====================================================
  // Word handshake into system clock; word is stable for a whole cycle
  logic [2:0] tgl_sync_reg;
  logic tgl_seen_reg;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tgl_sync_reg <= 3'h0;
      tgl_seen_reg <= 1'b0;
      irq_state_out <= SIRQ_DEFAULT_STATES; // R19
      irq_valid_out <= 1'b0;
      irq_update_out <= 1'b0;
    end else begin
      tgl_sync_reg <= {tgl_sync_reg[1:0], word_tgl_reg};
      irq_update_out <= 1'b0;
      if (tgl_sync_reg[1] == tgl_sync_reg[2] && tgl_sync_reg[2] != tgl_seen_reg) begin
        tgl_seen_reg <= tgl_sync_reg[2];
        irq_state_out <= word_reg;
        irq_valid_out <= 1'b1;
        irq_update_out <= 1'b1;
      end
    end
  end
endmodule // sirq_host

// >>> sirq_device.sv
// Function
// R1 - Line is open drain, shared by all
// R2 - All framing timed on the link clock
// R3 - Cycle: start, data frames, one stop
// R4 - Quiet start: one low clock, then release
// R5 - Host extends quiet start to 4..8 low
// R6 - Continuous mode: only host starts cycles
// R7 - Reset selects continuous mode
// R8 - Frame count starts at start rising edge
// R9 - Frame is sample, recovery, turn-around
// R10 - Sample phase: low if source active
// R11 - Recovery phase: drive high one clock
// R12 - Turn-around phase: line released
// R13 - Fixed slot order, sample every three clocks
// R14 - Frames 1..21 assigned, 22..32 unassigned
// R15 - Only host issues stop, 2 or 3 low
// R16 - Stop only after all frames end
// R17 - Stop width 2 quiet, 3 continuous
// R18 - Host runs first cycle after reset
// R19 - Host supplies defaults before first cycle
// R20 - Host in continuous before reconfiguration
// R21 - Quiet start only when idle and changed
// R22 - Low outside sample phase ends frames
module sirq_device (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [sirq_pkg::SIRQ_SOURCES-1:0] irq_req_in,
  output logic quiet_mode_out,
  sirq_if.device link
);
  import sirq_pkg::*;

  // =====================================================
  // Source levels into link domain
  logic [SIRQ_SOURCES-1:0] irq_s1_reg;
  logic [SIRQ_SOURCES-1:0] irq_s2_reg;
  logic [SIRQ_SOURCES-1:0] irq_s3_reg;
  logic [SIRQ_SOURCES-1:0] irq_live_reg;

  always_ff @(posedge link.link_clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_s1_reg <= SIRQ_DEFAULT_STATES;
      irq_s2_reg <= SIRQ_DEFAULT_STATES;
      irq_s3_reg <= SIRQ_DEFAULT_STATES;
    end else begin
      irq_s1_reg <= irq_req_in;
      irq_s2_reg <= irq_s1_reg;
      irq_s3_reg <= irq_s2_reg;
    end
  end

  // Per-bit filter: a change counts once two stages agree
  // Agreement also drops one-clock glitches
  genvar gi;
  generate
    for (gi = 0; gi < SIRQ_SOURCES; gi++) begin : g_live
      always_ff @(posedge link.link_clk or negedge rst_n_in) begin
        if (!rst_n_in) begin
          irq_live_reg[gi] <= SIRQ_DEFAULT_STATES[gi];
        end else if (irq_s2_reg[gi] == irq_s3_reg[gi]) begin
          irq_live_reg[gi] <= irq_s3_reg[gi];
        end
      end
    end
  endgenerate

  // =====================================================
  // Frame tracking on the link clock
  sirq_dev_state_t st_reg;
  logic [1:0] phase_reg;
  logic [4:0] frame_reg;
  logic done_reg;
  logic [1:0] stop_w_reg;
  logic quiet_reg;
  logic pulse_reg;
  logic recover_reg;
  logic [SIRQ_SOURCES-1:0] snap_reg;
  logic changed;
  logic own_low;

  // =====================================================
  // Assigned sample slot, used twice
  function automatic logic own_slot(input sirq_dev_state_t st, input logic [1:0] ph,
                                    input logic fin, input logic [4:0] fr);
    own_slot = (st == SIRQ_D_FRAMES) && (ph == SIRQ_PH_SAMPLE) && !fin &&
               (fr < 5'(SIRQ_SOURCES));
  endfunction

  assign changed = (irq_live_reg != snap_reg);
  assign own_low = pulse_reg ||
                   (own_slot(st_reg, phase_reg, done_reg, frame_reg) && snap_reg[frame_reg]);

  always_ff @(posedge link.link_clk or negedge rst_n_in) begin // R2
    if (!rst_n_in) begin
      st_reg <= SIRQ_D_IDLE;
      phase_reg <= SIRQ_PH_TURN;
      frame_reg <= 5'h0;
      done_reg <= 1'b0;
      stop_w_reg <= 2'h0;
    end else begin
      unique case (st_reg)
        SIRQ_D_IDLE: begin
          if (!link.serial_irq_line) begin
            st_reg <= SIRQ_D_START; // R3
          end
        end
        SIRQ_D_START: begin
          // Rising edge ending start is clock zero of the first frame
          if (link.serial_irq_line) begin
            st_reg <= SIRQ_D_FRAMES; // R8
            phase_reg <= SIRQ_PH_TURN;
            frame_reg <= 5'h0;
            done_reg <= 1'b0;
          end
        end
        SIRQ_D_FRAMES: begin
          // Sample-phase low is a request, not a stop
          if (!link.serial_irq_line && (phase_reg != SIRQ_PH_SAMPLE || done_reg)) begin
            st_reg <= SIRQ_D_STOP; // R22
            stop_w_reg <= 2'h1;
          end else begin
            unique case (phase_reg) // R9
              SIRQ_PH_SAMPLE: phase_reg <= SIRQ_PH_RECOVER;
              SIRQ_PH_RECOVER: phase_reg <= SIRQ_PH_TURN;
              default: phase_reg <= SIRQ_PH_SAMPLE;
            endcase
            if (phase_reg == SIRQ_PH_SAMPLE && !done_reg) begin
              if (frame_reg == SIRQ_LAST_FRAME) begin
                done_reg <= 1'b1; // R14
              end else begin
                frame_reg <= frame_reg + 5'h1; // R13
              end
            end
          end
        end
        SIRQ_D_STOP: begin
          if (!link.serial_irq_line) begin
            // Saturate: a long pulse still reads as continuous
            if (stop_w_reg != SIRQ_STOP_CONT) begin
              stop_w_reg <= stop_w_reg + 2'h1;
            end
          end else begin
            st_reg <= SIRQ_D_IDLE;
          end
        end
      endcase
    end
  end

  // Stop width picks next mode
  always_ff @(posedge link.link_clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quiet_reg <= SIRQ_QUIET_RST; // R7
    end else if (st_reg == SIRQ_D_STOP && link.serial_irq_line) begin
      quiet_reg <= (stop_w_reg == SIRQ_STOP_QUIET); // R17
    end
  end

  // Quiet start pulse, one clock, never in continuous mode
  always_ff @(posedge link.link_clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= (st_reg == SIRQ_D_IDLE) && quiet_reg && changed &&
                   link.serial_irq_line && !pulse_reg; // R4 R6 R21
    end
  end

  // Snapshot taken at start, reported through the cycle
  // Mid-cycle changes wait for the next cycle
  always_ff @(posedge link.link_clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      snap_reg <= SIRQ_DEFAULT_STATES;
    end else if (st_reg == SIRQ_D_IDLE && !link.serial_irq_line) begin
      snap_reg <= irq_live_reg;
    end
  end

  // Recovery follows each assigned sample slot
  always_ff @(posedge link.link_clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      recover_reg <= 1'b0;
    end else begin
      // Disagreeing sample: slot not ours, no high drive
      recover_reg <= own_slot(st_reg, phase_reg, done_reg, frame_reg) &&
                     link.serial_irq_line == !own_low; // R11
    end
  end

  // Drive low for pulse or active source, high only in recovery
  assign link.dev_oe = own_low || recover_reg; // R1 R10 R12
  assign link.dev_out = recover_reg; // R10 R11

  // =====================================================
  // Mode level back to system clock
  // Level only, so three stages suffice
  logic [2:0] mode_sync_reg;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_sync_reg <= 3'h0;
      quiet_mode_out <= SIRQ_QUIET_RST;
    end else begin
      mode_sync_reg <= {mode_sync_reg[1:0], quiet_reg};
      if (mode_sync_reg[1] == mode_sync_reg[2]) begin
        quiet_mode_out <= mode_sync_reg[2];
      end
    end
  end
endmodule // sirq_device

// >>> sirq_chk.sv
module sirq_chk (
  input wire logic link_clk,
  input wire logic rst_n_in,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic serial_irq_line
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] P_REC_END = 7'h3F;
  localparam logic [6:0] P_STOP = 7'h60;
  localparam logic [6:0] P_STOP3 = 7'h62;
  logic in_cyc_reg;
  logic quiet_reg;
  logic [6:0] pos_reg;
  logic [1:0] ph;
  // =====================================================
  // Frame position from the host's high clock
  assign ph = 2'(pos_reg % 7'h3);
  always_ff @(posedge link_clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_cyc_reg <= 1'b0;
    end else if (!in_cyc_reg && host_oe && host_out) begin
      in_cyc_reg <= 1'b1;
    end else if (pos_reg >= P_STOP3 && serial_irq_line) begin
      in_cyc_reg <= 1'b0;
    end
  end
  always_ff @(posedge link_clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pos_reg <= 7'h0;
    end else begin
      pos_reg <= in_cyc_reg ? pos_reg + 7'h1 : 7'h1;
    end
  end
  // Mode as the stop width left it
  always_ff @(posedge link_clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quiet_reg <= 1'b0;
    end else if (in_cyc_reg && pos_reg == P_STOP3) begin
      quiet_reg <= serial_irq_line;
    end
  end
  // =====================================================
  // Checks
  default clocking @(posedge link_clk); endclocking
  default disable iff (!rst_n_in);
  start_width_a: assert property (($fell(serial_irq_line) && !in_cyc_reg) |->
    !serial_irq_line [*4] ##1 serial_irq_line) else $error("start low time wrong");
  quiet_pulse_a: assert property ((!in_cyc_reg && dev_oe) |->
    !dev_out ##1 !dev_oe) else $error("device start pulse not one clock");
  pulse_idle_a: assert property ((!in_cyc_reg && dev_oe) |-> $past(serial_irq_line))
    else $error("device start on busy line");
  cont_silent_a: assert property ((!in_cyc_reg && !quiet_reg) |-> !dev_oe)
    else $error("device start in continuous mode");
  dev_sample_a: assert property ((in_cyc_reg && ph == 2'h2 && dev_oe) |-> !dev_out)
    else $error("device drove high in sample");
  dev_recover_a: assert property ((in_cyc_reg && ph == 2'h0 && pos_reg <= P_REC_END) |->
    dev_oe && dev_out) else $error("no recovery drive");
  dev_turn_a: assert property ((in_cyc_reg && ph == 2'h1) |-> !dev_oe)
    else $error("device drove in turn-around");
  dev_unused_a: assert property ((in_cyc_reg && pos_reg > P_REC_END) |-> !dev_oe)
    else $error("device drove unassigned slot");
  host_quiet_a: assert property ((in_cyc_reg && pos_reg < P_STOP) |-> !host_oe)
    else $error("host drove during frames");
  stop_width_a: assert property ((in_cyc_reg && pos_reg == P_STOP) |->
    !serial_irq_line [*2] ##2 serial_irq_line) else $error("stop width wrong");
endmodule // sirq_chk

// >>> serial_irq_peripheral_test.sv
module serial_irq_peripheral_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sirq_pkg::*;
  `define CHK(got, exp) begin \
    checks++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
  logic clock_in = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n_in = 1'b0;
  logic quiet_req_in = 1'b0;
  logic q;
  logic e_mode;
  logic quiet_mode_out;
  logic irq_valid_out;
  logic irq_update_out;
  logic [SIRQ_SOURCES-1:0] irq_req_in = '0;
  logic [SIRQ_SOURCES-1:0] irq_state_out;
  logic [SIRQ_SOURCES-1:0] nxt;
  logic [SIRQ_SOURCES-1:0] e_state;
  logic [SIRQ_SOURCES-1:0] exp_state_q[$];
  logic exp_mode_q[$];
  logic [SIRQ_SOURCES-1:0] pat [4] = '{21'h1FFFFF, 21'h000001, 21'h100000, 21'h000004};
  logic quiet_pat [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 74;
  // =====================================================
  // Clocks and the joined ends
  always #12.5 clock_in = ~clock_in;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  sirq_if u_sirq_if (.link_clk(link_clk));
  sirq_device u_sirq_device (.clock_in(clock_in), .rst_n_in(rst_n_in), .irq_req_in(irq_req_in),
    .quiet_mode_out(quiet_mode_out), .link(u_sirq_if));
  sirq_host u_sirq_host (.clock_in(clock_in), .rst_n_in(rst_n_in), .quiet_req_in(quiet_req_in),
    .irq_state_out(irq_state_out), .irq_valid_out(irq_valid_out),
    .irq_update_out(irq_update_out), .link(u_sirq_if));
  sirq_chk u_sirq_chk (.link_clk(link_clk), .rst_n_in(rst_n_in), .dev_out(u_sirq_if.dev_out),
    .dev_oe(u_sirq_if.dev_oe), .host_out(u_sirq_if.host_out), .host_oe(u_sirq_if.host_oe),
    .serial_irq_line(u_sirq_if.serial_irq_line));
  // =====================================================
  // Verdict
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      $display("Error at %0t: run did not finish", $time);
      close_out();
    end
  end
  // =====================================================
  // Monitor: one note per delivered cycle
  always @(posedge clock_in) begin
    if (rst_n_in && irq_update_out === 1'b1) begin
      e_state = exp_state_q.pop_front();
      e_mode = exp_mode_q.pop_front();
      `CHK(irq_valid_out, 1'b1)
      `CHK(irq_state_out, e_state)
      `CHK(quiet_mode_out, e_mode)
    end
  end
  // =====================================================
  // Stimulus; mode change waits out the running stop
  initial begin
    exp_state_q.push_back('0);
    exp_mode_q.push_back(1'b0);
    exp_mode_q.push_back(1'b0);
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    #1;
    `CHK(irq_valid_out, 1'b0)
    `CHK(irq_state_out, SIRQ_DEFAULT_STATES)
    for (int i = 0; i < 12; i++) begin
      do @(posedge clock_in); while (irq_update_out !== 1'b1);
      nxt = (i < 4) ? pat[i] : SIRQ_SOURCES'($random(seed));
      q = (i < 4) ? quiet_pat[i] : 1'($random(seed));
      // Last request is continuous, so the device ends in continuous mode
      if (i == 11) q = 1'b0;
      // Quiet mode only starts on a change
      if (nxt == irq_req_in) nxt = ~nxt;
      irq_req_in <= nxt;
      exp_state_q.push_back(nxt);
      repeat (20) @(posedge clock_in);
      quiet_req_in <= q;
      exp_mode_q.push_back(q);
    end
    // Final cycle repeats the last states in continuous mode
    exp_state_q.push_back(nxt);
    repeat (2) begin
      do @(posedge clock_in); while (irq_update_out !== 1'b1);
    end
    repeat (40) @(posedge clock_in);
    `CHK(quiet_mode_out, 1'b0)
    close_out();
  end
endmodule // serial_irq_peripheral_test
